// ---- rtl/ccl_map.vh ----
// Function
// - top priority bit set when level exceeds seven
// - level is top bit above status bits 7:5
// - stack frame active: w14/w15 flat 16-bit addressing
// - stack frame inactive: normal paged addressing
// - rounding select one biased, zero convergent
// - multiply select one integer, zero fractional
`ifndef CCL_MAP_VH
`define CCL_MAP_VH
// ****************************************
// register offsets
// ****************************************
`define CCL_CTRL_OFFSET   12'h000
`define CCL_STAT_OFFSET   12'h004
// ****************************************
// field positions
// ****************************************
`define CCL_MUL_INT_BIT   0
`define CCL_RND_BIT       1
`define CCL_SFA_BIT       2
`define CCL_IPL_TOP_BIT   3
`define CCL_SR_IPL_HI     7
`define CCL_SR_IPL_LO     5
`define CCL_IPL_MAX_LOW   4'h7
// ****************************************
// reset values
// ****************************************
`define CCL_CTRL_RESET    4'h0
`define CCL_SFA_RESET     1'b0
`endif

// ---- rtl/ccl_sync_mode.v ----
`timescale 1ns/1ps
// ****************************************
// mode latch: releases new modes between dsp ops
// ****************************************
module ccl_sync_mode #(
  parameter W = 2
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire [W-1:0] mode_in,
  input  wire         dsp_busy,
  output reg  [W-1:0] mode_out
);
  // hold current mode while an operation runs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_out <= {W{1'b0}};
    end else if (!dsp_busy) begin
      mode_out <= mode_in;
    end
  end
endmodule

// ---- rtl/ccl_core_ctrl.v ----
`timescale 1ns/1ps
`include "ccl_map.vh"
// ****************************************
// core mode control low bits, apb slave
// ****************************************
module ccl_core_ctrl (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire [7:0]  cpu_status_register,
  input  wire        priority_level_top_bit_in,
  input  wire        stack_frame_active_in,
  input  wire        sfa_load,
  input  wire        dsp_busy,
  input  wire        ea_from_wreg,
  input  wire [15:0] ea_in,
  input  wire [9:0]  data_read_page,
  input  wire [8:0]  data_write_page,
  input  wire        ea_is_write,
  output reg  [23:0] ea_out,
  output reg  [3:0]  priority_level,
  output wire        rounding_biased,
  output wire        multiply_integer
);
  // ****************************************
  // state
  // ****************************************
  reg  [1:0] mode_r;        // rnd, integer mode written by software
  reg        sfa_r;         // stack frame active status
  reg        ipl_top_r;     // top priority level bit
  wire [1:0] mode_live;     // mode seen by the dsp
  wire       wr_en;         // apb write strobe
  wire       rd_en;         // apb read strobe
  wire       hit_ctrl;      // control decode
  wire       hit_stat;      // status decode
  wire [3:0] ctrl_rd;       // readback of low four bits
  wire [2:0] ipl_low;       // low priority bits from status reg

  assign wr_en    = psel & penable & pwrite;
  assign rd_en    = psel & penable & ~pwrite;
  assign hit_ctrl = (paddr == `CCL_CTRL_OFFSET);
  assign hit_stat = (paddr == `CCL_STAT_OFFSET);
  assign pready   = 1'b1;
  // unmapped address answers with an error
  assign pslverr  = psel & penable & ~(hit_ctrl | hit_stat);
  assign ipl_low  = cpu_status_register[`CCL_SR_IPL_HI:`CCL_SR_IPL_LO];

  // ****************************************
  // registers
  // ****************************************
  // software writes modes, hardware updates status bits
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r    <= 2'b00;
      sfa_r     <= `CCL_SFA_RESET;
      ipl_top_r <= 1'b0;
    end else begin
      if (wr_en && hit_ctrl) begin
        mode_r <= {pwdata[`CCL_RND_BIT], pwdata[`CCL_MUL_INT_BIT]};
      end
      if (sfa_load) begin
        sfa_r <= stack_frame_active_in;
      end
      ipl_top_r <= priority_level_top_bit_in;
    end
  end

  // ****************************************
  // priority level
  // ****************************************
  // joined level and top bit consistency
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      priority_level <= 4'h0;
    end else begin
      priority_level <= {ipl_top_r, ipl_low};
    end
  end

  assign ctrl_rd = {ipl_top_r, sfa_r, mode_r};

  // ****************************************
  // read data
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (hit_ctrl) begin
        prdata <= {28'h000_0000, ctrl_rd};
      end else if (hit_stat) begin
        prdata <= {28'h000_0000, ipl_top_r, 1'b0, mode_live};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ****************************************
  // dsp modes, held across running ops
  // ****************************************
  ccl_sync_mode #(
    .W (2)
  ) u_mode (
    .pclk     (pclk),
    .presetn  (presetn),
    .mode_in  (mode_r),
    .dsp_busy (dsp_busy),
    .mode_out (mode_live)
  );
  assign rounding_biased  = mode_live[1];
  assign multiply_integer = mode_live[0];

  // ****************************************
  // w14/w15 effective address
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ea_out <= 24'h00_0000;
    end else if (ea_from_wreg && sfa_r) begin
      ea_out <= {8'h00, ea_in};
    end else if (!ea_in[15]) begin
      ea_out <= {8'h00, ea_in};
    end else if (ea_is_write) begin
      ea_out <= {data_write_page, ea_in[14:0]};
    end else begin
      ea_out <= {data_read_page[8:0], ea_in[14:0]};
    end
  end
  wire unused_rd = rd_en | data_read_page[9] | ipl_low[0] & 1'b0;
endmodule

// ---- test/ccl_chk_sva.sv ----
`timescale 1ns/1ps
// ****************************************
// checker on the core mode control ports
// ****************************************
module ccl_chk (
  input wire        pclk, presetn, psel, penable, pwrite, sfa_load,
  input wire        stack_frame_active_in, dsp_busy, ea_from_wreg,
  input wire        priority_level_top_bit_in,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [7:0]  cpu_status_register,
  input wire [15:0] ea_in,
  input wire [23:0] ea_out,
  input wire [3:0]  priority_level,
  input wire        rounding_biased, multiply_integer
);
  reg s_r; // last loaded stack frame state
  // shadow of the stack frame flag
  always @(posedge pclk or negedge presetn)
    if (!presetn) s_r <= 1'b0;
    else if (sfa_load) s_r <= stack_frame_active_in;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_TOP: assert property ($past(presetn, 3) |->
    priority_level[3] == $past(priority_level_top_bit_in, 2))
    else $error("top priority bit wrong");
  AST_LOW: assert property ($past(presetn, 3) |->
    priority_level[2:0] == $past(cpu_status_register[7:5]))
    else $error("low priority bits wrong");
  AST_FLAT: assert property ($past(ea_from_wreg && s_r && !sfa_load)
    |-> ea_out == {8'h00, $past(ea_in)}) else $error("flat address wrong");
  AST_BASE: assert property ($past(ea_from_wreg && !s_r && !sfa_load
    && !ea_in[15]) |-> ea_out == {8'h00, $past(ea_in)})
    else $error("base address wrong");
  AST_RND: assert property (psel && penable && pwrite && paddr == 12'h000
    ##1 !dsp_busy |=> rounding_biased == $past(pwdata[1], 2))
    else $error("rounding mode wrong");
  AST_MUL: assert property (psel && penable && pwrite && paddr == 12'h000
    ##1 !dsp_busy |=> multiply_integer == $past(pwdata[0], 2))
    else $error("multiply mode wrong");
  AST_HOLD: assert property (dsp_busy |=>
    $stable({rounding_biased, multiply_integer}))
    else $error("mode changed while busy");
endmodule
bind ccl_core_ctrl ccl_chk u_chk (.*);

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done = checks_done + 1; if ((a) !== (b)) \
  begin n_fail = n_fail + 1; $display("[FAIL] %0t %h %h", $time, a, b); end end
// ****************************************
// bench: apb master and mode model
// ****************************************
module tb_top;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
  reg sfa_load = 0, stack_frame_active_in = 0, dsp_busy = 0;
  reg ea_from_wreg = 0, ea_is_write = 0, priority_level_top_bit_in = 0;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0, rd;
  reg [7:0]  cpu_status_register = 0;
  reg [15:0] ea_in = 0;
  reg [9:0]  data_read_page = 0;
  reg [8:0]  data_write_page = 0;
  wire [31:0] prdata;
  wire [23:0] ea_out;
  wire [3:0]  priority_level;
  wire pready, pslverr, rounding_biased, multiply_integer;
  integer n_fail = 0, checks_done = 0, seed = 90952, i, e, m = 0, p, q;
  ccl_core_ctrl dut (.*);
  initial forever #50 pclk = ~pclk;
  // verdict and end of run
  task summarize; begin
    if (n_fail == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  end endtask
  // one apb transfer, held until pready
  task apb(input w, input [11:0] a, input [31:0] d); begin
    @(posedge pclk); psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk); penable <= 1;
    @(posedge pclk); while (pready !== 1'b1) @(posedge pclk);
    rd = prdata; er = pslverr;
    psel <= 0; penable <= 0;
  end endtask
  initial begin #100000; n_fail = n_fail + 1; summarize; end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    for (i = 0; i < 16; i = i + 1) begin // modes, busy holds, priority
      e = $random(seed);
      dsp_busy <= i[2];
      cpu_status_register <= e[7:0];
      priority_level_top_bit_in <= e[8];
      apb(1, 12'h000, e);
      repeat (3) @(posedge pclk);
      `CHK(priority_level, {e[8], e[7:5]})
      if (!i[2]) m = e;
      `CHK({rounding_biased, multiply_integer}, m[1:0])
      m = e;
      dsp_busy <= 0;
      apb(0, 12'h000, 32'h0000_0000);
      `CHK(rd[3:0], {e[8], 1'b0, e[1:0]})
    end
    apb(0, 12'h008, 32'h0000_0000); // unmapped place refused
    `CHK({er, rd}, {1'b1, 32'h0000_0000})
    for (i = 0; i < 2; i = i + 1) begin // flat then paged w14/w15
      stack_frame_active_in <= !i;
      sfa_load <= 1;
      @(posedge pclk); sfa_load <= 0;
      e = $random(seed) | 32'h0000_8000;
      p = $random(seed);
      q = $random(seed);
      ea_in <= e[15:0]; ea_from_wreg <= 1; ea_is_write <= e[0];
      data_read_page <= p[9:0]; data_write_page <= q[8:0];
      repeat (2) @(posedge pclk);
      if (!i) `CHK(ea_out, {8'h00, e[15:0]})
      else if (e[0]) `CHK(ea_out, {q[8:0], e[14:0]})
      else `CHK(ea_out, {p[8:0], e[14:0]})
    end
    summarize;
  end
endmodule
